// >>> src/sop_pkg.sv
/*
 * Constants shared by the sum-of-products macrocell array and its
 * pattern memory: array shape, product-term layout, register-port map,
 * pin vector layout and values after reset.
 * Assumes a single 20 MHz system clock and an active-low async reset.
 */
package sop_pkg;

   ////////////////////////////////////////////////////////////////////
   // Array shape
   localparam int SOP_N_IN  = 12;
   localparam int SOP_N_MC  = 10;
   localparam int SOP_N_SIG = SOP_N_IN + SOP_N_MC;
   localparam int SOP_N_COL = 2 * SOP_N_SIG;
   localparam int SOP_N_PT  = 132;
   localparam int SOP_PT_MAX = 16;

   // Term 0 is the async reset, the last term the sync preset
   localparam int SOP_PT_AR = 0;
   localparam int SOP_PT_SP = 131;

   // Per macrocell: index of its enable term, data terms follow it
   localparam int SOP_PT_OE  [SOP_N_MC] = '{1, 10, 21, 34, 49, 66, 83, 98, 111, 122};
   localparam int SOP_PT_CNT [SOP_N_MC] = '{8, 10, 12, 14, 16, 16, 14, 12, 10, 8};

   ////////////////////////////////////////////////////////////////////
   // Register port
   localparam int SOP_AW = 9;
   localparam int SOP_DW = 32;
   localparam int SOP_FUSE_WORDS = 2 * SOP_N_PT;
   localparam int SOP_FUSE_HI_BITS = SOP_N_COL - SOP_DW;

   localparam logic [SOP_AW-1:0] SOP_ADDR_FUSE_END = 9'h108;
   localparam logic [SOP_AW-1:0] SOP_ADDR_CFG      = 9'h108;
   localparam logic [SOP_AW-1:0] SOP_ADDR_STAT     = 9'h109;

   localparam int SOP_CFG_POL_LSB  = 0;
   localparam int SOP_CFG_BYP_LSB  = 16;
   localparam int SOP_STAT_Q_LSB   = 0;
   localparam int SOP_STAT_OE_LSB  = 16;

   ////////////////////////////////////////////////////////////////////
   // Pin vector seen by the input synchroniser
   localparam int SOP_PIN_IN_LSB = 0;
   localparam int SOP_PIN_IO_LSB = 12;
   localparam int SOP_PIN_CLK    = 22;
   localparam int SOP_PIN_PRE    = 23;
   localparam int SOP_N_PIN      = 24;

   ////////////////////////////////////////////////////////////////////
   // Values after reset
   localparam logic [SOP_N_MC-1:0]  SOP_Q_RST    = 10'h000;
   localparam logic [SOP_N_MC-1:0]  SOP_POL_RST  = 10'h3FF;
   localparam logic [SOP_N_MC-1:0]  SOP_BYP_RST  = 10'h3FF;
   localparam logic [SOP_N_PIN-1:0] SOP_PIN_RST  = 24'h000000;
   localparam logic [SOP_DW-1:0]    SOP_WORD_RST = 32'h00000000;

endpackage : sop_pkg

// >>> src/sop_fuse_mem.sv
/*
 * Pattern memory for the product-term array: word-wide writes, a
 * registered read port, and the whole pattern exposed in parallel for
 * evaluation.
 * Assumes the caller decodes the address range and never reads and
 * writes in the same cycle.
 */
module sop_fuse_mem
   import sop_pkg::*;
#(
   parameter int WORDS = SOP_FUSE_WORDS,
   parameter int WIDTH = SOP_DW,
   parameter int AW    = SOP_AW
) (
   input  wire logic                   i_clk,
   input  wire logic                   i_reset_n,
   input  wire logic                   i_we,
   input  wire logic                   i_re,
   input  wire logic [AW-1:0]          i_addr,
   input  wire logic [WIDTH-1:0]       i_wdata,
   output logic      [WIDTH-1:0]       o_rdata,
   output logic      [WORDS*WIDTH-1:0] o_array
);

   typedef struct packed {
      logic [WORDS-1:0][WIDTH-1:0] mem;
      logic [WIDTH-1:0]            rdata;
   } sop_mem_s;

   sop_mem_s st_r;
   sop_mem_s st_nxt;

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      st_nxt = st_r;
      if (i_we && (int'(i_addr) < WORDS)) begin
         st_nxt.mem[i_addr] = i_wdata;
      end
      if (i_re && (int'(i_addr) < WORDS)) begin
         st_nxt.rdata = st_r.mem[i_addr];
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_rdata = st_r.rdata;
   assign o_array = st_r.mem;

endmodule : sop_fuse_mem

// >>> src/sop_macrocell_array.sv
/*
 * Programmable sum-of-products array with ten output macrocells.
 * The AND pattern sits in a loadable memory, the macrocell
 * configuration in a register; pins are sampled through synchronisers.
 * Assumes the wire level of each I/O pin is resolved outside from
 * o_io_out and o_io_oe and returned on i_io_in; the device clock pin
 * is far slower than i_clk.
 */
// Our own choices: the address-and-strobe port and the register addresses.
//
// Overview of operation
// - Twelve dedicated inputs and ten macrocells, each usable as bidirectional pin.
// - Outputs get unequal data product-term counts, eight up to sixteen.
// - Array sees every input both true and inverted.
// - A product term with no connections evaluates HIGH.
// - Term using true and complement of one input evaluates LOW.
// - Four macrocell modes: registered or combinatorial, active low or high.
// - Programmed configuration bit reads 0, erased bit reads 1.
// - Macrocell flip-flop captures OR sum on rising device clock edge.
// - Bypass select 0: output from flip-flop, inverted state fed back.
// - Bypass select 1: sum bypasses flip-flop, feedback taken from pin.
// - Each output buffer enabled by its own dedicated product term.
// - Combinatorial cell with disabled buffer acts as dedicated input.
// - Polarity bit 1 gives active-high output, 0 gives active-low.
// - Shared sync preset term loads all flip-flops HIGH on clock edge.
// - Shared async reset term forces all flip-flops LOW without clock.
// - Preset and reset act on state; pin level follows via polarity.
// - Reset clears every macrocell flip-flop to LOW.
// - Test preload loads flip-flops directly from values on output pins; the code loads the inverted pin value where the polarity bit is 0.
//
module sop_macrocell_array
   import sop_pkg::*;
(
   input  wire logic                i_clk,
   input  wire logic                i_reset_n,
   input  wire logic [SOP_N_IN-1:0] i_in,
   input  wire logic [SOP_N_MC-1:0] i_io_in,
   output logic      [SOP_N_MC-1:0] o_io_out,
   output logic      [SOP_N_MC-1:0] o_io_oe,
   input  wire logic                i_dev_clk,
   input  wire logic                i_preload,
   input  wire logic [SOP_AW-1:0]   i_addr,
   input  wire logic [SOP_DW-1:0]   i_wdata,
   input  wire logic                i_wr,
   input  wire logic                i_rd,
   output logic      [SOP_DW-1:0]   o_rdata
);

   typedef struct packed {
      logic [SOP_N_PIN-1:0] s1;
      logic [SOP_N_PIN-1:0] s2;
      logic [SOP_N_PIN-1:0] s3;
      logic [SOP_N_PIN-1:0] f;
      logic [SOP_N_MC-1:0]  q;
      logic [SOP_N_MC-1:0]  pol;
      logic [SOP_N_MC-1:0]  byp;
      logic [SOP_N_MC-1:0]  out;
      logic [SOP_N_MC-1:0]  oe;
      logic [SOP_DW-1:0]    rdata;
      logic                 rd_mem;
      logic                 rd_vld;
   } sop_state_s;

   sop_state_s st_r;
   sop_state_s st_nxt;

   logic [SOP_FUSE_WORDS*SOP_DW-1:0] fuse_flat;
   logic [SOP_DW-1:0]                mem_rdata;
   logic                             fuse_sel;

   ////////////////////////////////////////////////////////////////////
   // Product term: fuse bit 1 connects a column into the AND gate
   function automatic logic sop_pterm(input logic [SOP_N_COL-1:0] fuse,
                                      input logic [SOP_N_COL-1:0] col);
      sop_pterm = &(~fuse | col);
   endfunction : sop_pterm

   ////////////////////////////////////////////////////////////////////
   // Pattern memory
   assign fuse_sel = (i_addr < SOP_ADDR_FUSE_END);

   sop_fuse_mem #(
      .WORDS (SOP_FUSE_WORDS),
      .WIDTH (SOP_DW),
      .AW    (SOP_AW)
   ) u_fuse (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_we      (i_wr && fuse_sel),
      .i_re      (i_rd && fuse_sel),
      .i_addr    (i_addr),
      .i_wdata   (i_wdata),
      .o_rdata   (mem_rdata),
      .o_array   (fuse_flat)
   );

   ////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      logic [SOP_N_PIN-1:0]  pins;
      logic [SOP_N_PIN-1:0]  agree;
      logic [SOP_N_SIG-1:0]  sig;
      logic [SOP_N_COL-1:0]  col;
      logic [SOP_N_COL-1:0]  fuse;
      logic [SOP_N_PT-1:0]   term;
      logic [SOP_N_MC-1:0]   sum;
      logic [SOP_N_MC-1:0]   fb;
      logic [SOP_N_MC-1:0]   io_f;
      logic [SOP_N_MC-1:0]   q_st;
      logic                  clk_rise;
      logic                  pre_f;
      logic                  ar;
      logic                  sp;
      pins     = '0;
      agree    = '0;
      sig      = '0;
      col      = '0;
      fuse     = '0;
      term     = '0;
      sum      = '0;
      fb       = '0;
      io_f     = '0;
      q_st     = '0;
      clk_rise = 1'b0;
      pre_f    = 1'b0;
      ar       = 1'b0;
      sp       = 1'b0;
      st_nxt   = st_r;

      // Three-stage pin sampling; a change counts once stages 2 and 3 agree
      pins[SOP_PIN_IN_LSB +: SOP_N_IN] = i_in;
      pins[SOP_PIN_IO_LSB +: SOP_N_MC] = i_io_in;
      pins[SOP_PIN_CLK]                = i_dev_clk;
      pins[SOP_PIN_PRE]                = i_preload;
      st_nxt.s1 = pins;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      agree     = ~(st_r.s2 ^ st_r.s3);
      st_nxt.f  = (st_r.s2 & agree) | (st_r.f & ~agree);
      clk_rise  = st_nxt.f[SOP_PIN_CLK] & ~st_r.f[SOP_PIN_CLK];
      pre_f     = st_r.f[SOP_PIN_PRE];
      io_f      = st_r.f[SOP_PIN_IO_LSB +: SOP_N_MC];

      // Feedback: flip-flop state inverted, or the pin itself
      for (int j = 0; j < SOP_N_MC; j++) begin
         fb[j] = st_r.byp[j] ? io_f[j] : ~st_r.q[j];
      end
      sig = {fb, st_r.f[SOP_PIN_IN_LSB +: SOP_N_IN]};
      col = {~sig, sig};

      // AND array
      for (int t = 0; t < SOP_N_PT; t++) begin
         fuse = {fuse_flat[(2*t+1)*SOP_DW +: SOP_FUSE_HI_BITS],
                 fuse_flat[2*t*SOP_DW +: SOP_DW]};
         term[t] = sop_pterm(fuse, col);
      end
      ar = term[SOP_PT_AR];
      sp = term[SOP_PT_SP];

      // Fixed OR array with per-output term counts
      for (int j = 0; j < SOP_N_MC; j++) begin
         for (int k = 0; k < SOP_PT_MAX; k++) begin
            if (k < SOP_PT_CNT[j]) begin
               sum[j] = sum[j] | term[SOP_PT_OE[j] + 1 + k];
            end
         end
      end

      // Flip-flop state
      q_st = st_r.q;
      if (ar) begin
         q_st = SOP_Q_RST;
      end else if (clk_rise) begin
         if (pre_f) begin
            q_st = ~(io_f ^ st_r.pol);
         end else if (sp) begin
            q_st = '1;
         end else begin
            q_st = sum;
         end
      end
      st_nxt.q = q_st;

      // Output mux, polarity and buffer enable
      for (int j = 0; j < SOP_N_MC; j++) begin
         if (st_r.byp[j]) begin
            st_nxt.out[j] = st_r.pol[j] ? sum[j] : ~sum[j];
         end else begin
            st_nxt.out[j] = st_r.pol[j] ? q_st[j] : ~q_st[j];
         end
         st_nxt.oe[j] = term[SOP_PT_OE[j]] & ~pre_f;
      end

      // Register port: configuration write, reads one cycle later
      if (i_wr && (i_addr == SOP_ADDR_CFG)) begin
         st_nxt.pol = i_wdata[SOP_CFG_POL_LSB +: SOP_N_MC];
         st_nxt.byp = i_wdata[SOP_CFG_BYP_LSB +: SOP_N_MC];
      end
      st_nxt.rd_vld = i_rd;
      st_nxt.rd_mem = i_rd && fuse_sel;
      st_nxt.rdata  = SOP_WORD_RST;
      if (i_rd && (i_addr == SOP_ADDR_CFG)) begin
         st_nxt.rdata[SOP_CFG_POL_LSB +: SOP_N_MC] = st_r.pol;
         st_nxt.rdata[SOP_CFG_BYP_LSB +: SOP_N_MC] = st_r.byp;
      end else if (i_rd && (i_addr == SOP_ADDR_STAT)) begin
         st_nxt.rdata[SOP_STAT_Q_LSB +: SOP_N_MC]  = st_r.q;
         st_nxt.rdata[SOP_STAT_OE_LSB +: SOP_N_MC] = st_r.oe;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_r.s1     <= SOP_PIN_RST;
         st_r.s2     <= SOP_PIN_RST;
         st_r.s3     <= SOP_PIN_RST;
         st_r.f      <= SOP_PIN_RST;
         st_r.q      <= SOP_Q_RST;
         st_r.pol    <= SOP_POL_RST;
         st_r.byp    <= SOP_BYP_RST;
         st_r.out    <= '0;
         st_r.oe     <= '0;
         st_r.rdata  <= SOP_WORD_RST;
         st_r.rd_mem <= 1'b0;
         st_r.rd_vld <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs
   assign o_io_out = st_r.out;
   assign o_io_oe  = st_r.oe;
   assign o_rdata  = !st_r.rd_vld ? SOP_WORD_RST : (st_r.rd_mem ? mem_rdata : st_r.rdata);

endmodule : sop_macrocell_array

// >>> test/sop_macrocell_array_asserts.sv
/* Port assertions for the macrocell array.
   Bound to the top module from the bench's top file. */
module sop_macrocell_array_asserts
   import sop_pkg::*;
(
   input wire logic                i_clk,
   input wire logic                i_reset_n,
   input wire logic [SOP_N_MC-1:0] o_io_out,
   input wire logic [SOP_N_MC-1:0] o_io_oe,
   input wire logic                i_preload,
   input wire logic [SOP_AW-1:0]   i_addr,
   input wire logic [SOP_DW-1:0]   i_wdata,
   input wire logic                i_wr,
   input wire logic                i_rd,
   input wire logic [SOP_DW-1:0]   o_rdata
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);

   property p_rst_out;
      $rose(i_reset_n) |-> o_io_out == '0 && o_io_oe == '0 && o_rdata == '0;
   endproperty
   a_rst_out: assert property (p_rst_out)
      else $error("outputs not cleared by reset");

   property p_pl_oe;
      i_preload [*8] |-> o_io_oe == '0;
   endproperty
   a_pl_oe: assert property (p_pl_oe)
      else $error("pin driven during preload");

   property p_stat_oe;
      i_rd && i_addr == SOP_ADDR_STAT |=> o_rdata[25:16] == $past(o_io_oe);
   endproperty
   a_stat_oe: assert property (p_stat_oe)
      else $error("status enable field differs from pins");

   property p_cfg_rb;
      i_wr && i_addr == SOP_ADDR_CFG ##1 !i_wr ##1 i_rd && i_addr == SOP_ADDR_CFG
      |=> o_rdata[9:0] == $past(i_wdata[9:0], 3)
          && o_rdata[25:16] == $past(i_wdata[25:16], 3);
   endproperty
   a_cfg_rb: assert property (p_cfg_rb)
      else $error("config readback wrong");

   property p_fuse_rb;
      i_wr && i_addr < SOP_ADDR_FUSE_END ##1 !i_wr
      ##1 i_rd && i_addr == $past(i_addr, 2) |=> o_rdata == $past(i_wdata, 3);
   endproperty
   a_fuse_rb: assert property (p_fuse_rb)
      else $error("pattern word readback wrong");

   property p_rd_idle;
      !$past(i_rd) |-> o_rdata == '0;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside read slot");

   property p_unmap;
      i_rd && i_addr > SOP_ADDR_STAT |=> o_rdata == '0;
   endproperty
   a_unmap: assert property (p_unmap)
      else $error("unmapped read not zero");

   property p_stat_rsv;
      i_rd && i_addr == SOP_ADDR_STAT |=> o_rdata[31:26] == '0 && o_rdata[15:10] == '0;
   endproperty
   a_stat_rsv: assert property (p_stat_rsv)
      else $error("status spare bits set");
endmodule : sop_macrocell_array_asserts

// >>> test/sop_pins.sv
/* Board side of the I/O pins: resolves each wire level.
   Assumes the bench drives i_drv where the device is off. */
module sop_pins
   import sop_pkg::*;
(
   input  wire logic [SOP_N_MC-1:0] i_out,
   input  wire logic [SOP_N_MC-1:0] i_oe,
   input  wire logic [SOP_N_MC-1:0] i_drv,
   input  wire logic [SOP_N_MC-1:0] i_drv_en,
   output logic      [SOP_N_MC-1:0] o_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // Undriven pin floats high by pull-up
   always_comb begin
      for (int j = 0; j < SOP_N_MC; j++) begin
         o_pin[j] = i_oe[j] ? i_out[j] : (i_drv_en[j] ? i_drv[j] : 1'b1);
      end
   end
endmodule : sop_pins

// >>> test/sop_macrocell_array_bench.sv
/* Self-checking bench for the macrocell array.
   Assumes the board pins are resolved by sop_pins. */
module sop_macrocell_array_bench
   import sop_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [43:0] pt_low = 44'h00000400001;
   logic                i_clk, i_reset_n, i_dev_clk, i_preload, i_wr, i_rd;
   logic [SOP_N_IN-1:0] i_in;
   logic [SOP_N_MC-1:0] i_io_in, o_io_out, o_io_oe, drv, drv_en;
   logic [SOP_AW-1:0]   i_addr;
   logic [SOP_DW-1:0]   i_wdata, o_rdata, d;
   int                  miscompares, n_tests;

   sop_macrocell_array uut (.i_clk, .i_reset_n, .i_in, .i_io_in, .o_io_out, .o_io_oe,
      .i_dev_clk, .i_preload, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata);
   sop_pins u_pins (.i_out(o_io_out), .i_oe(o_io_oe), .i_drv(drv), .i_drv_en(drv_en),
      .o_pin(i_io_in));

   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end

   ////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("tests %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input string n, input logic [SOP_DW-1:0] e, input logic [SOP_DW-1:0] g);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask : chk

   task automatic wr(input logic [SOP_AW-1:0] a, input logic [SOP_DW-1:0] v);
      @(posedge i_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= v;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [SOP_AW-1:0] a);
      @(posedge i_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      @(negedge i_clk);
      d = o_rdata;
   endtask : rd

   task automatic pt(input int t, input logic [43:0] v);
      wr(9'(2 * t), v[31:0]);
      wr(9'(2 * t + 1), {20'h00000, v[43:32]});
   endtask : pt

   // Waits out the pin samplers
   task automatic st;
      repeat (8) @(posedge i_clk);
      @(negedge i_clk);
   endtask : st

   task automatic setin(input int b, input logic v);
      @(posedge i_clk);
      i_in[b] <= v;
      st();
   endtask : setin

   task automatic tck;
      @(posedge i_clk);
      i_dev_clk <= 1'b1;
      repeat (6) @(posedge i_clk);
      i_dev_clk <= 1'b0;
      st();
   endtask : tck

   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge i_clk);
      miscompares++;
      print_verdict();
   end

   initial begin
      {i_reset_n, i_dev_clk, i_preload, i_wr, i_rd} = 5'h00;
      {i_in, i_addr, i_wdata, drv, drv_en} = '0;
      miscompares = 0;
      n_tests = 0;
      repeat (4) @(posedge i_clk);
      i_reset_n <= 1'b1;
      st();
      rd(SOP_ADDR_CFG);
      chk("cfg", 32'h03FF03FF, d);
      wr(SOP_ADDR_STAT, 32'hFFFFFFFF);
      rd(SOP_ADDR_STAT);
      chk("stat", 32'h03FF0000, d);
      rd(9'h10A);
      chk("unmapped", 32'h0, d);
      wr(9'h005, 32'hA5A5F00F);
      rd(9'h005);
      chk("fuse", 32'hA5A5F00F, d);
      pt(0, pt_low);
      pt(131, pt_low);
      for (int t = 3; t < 10; t++) pt(t, pt_low);
      pt(10, pt_low);
      pt(2, '0);
      wr(SOP_ADDR_CFG, 32'h03FE03FF);
      rd(SOP_ADDR_CFG);
      chk("cfg_rb", 32'h03FE03FF, d);
      st();
      chk("reg_lo", 0, o_io_out[0]);
      tck();
      chk("reg_hi", 1, o_io_out[0]);
      chk("oe", 1, o_io_oe[0]);
      wr(SOP_ADDR_CFG, 32'h03FE03FE);
      st();
      chk("pol_lo", 0, o_io_out[0]);
      wr(SOP_ADDR_CFG, 32'h03FE03FF);
      pt(2, 44'h1000);
      tck();
      chk("fb_a", 0, o_io_out[0]);
      tck();
      chk("fb_b", 1, o_io_out[0]);
      pt(0, 44'h4);
      setin(2, 1'b1);
      chk("ar", 0, o_io_out[0]);
      setin(2, 1'b0);
      pt(131, 44'h8);
      pt(2, pt_low);
      wr(SOP_ADDR_CFG, 32'h000003FF);
      setin(3, 1'b1);
      tck();
      rd(SOP_ADDR_STAT);
      chk("sp", 10'h3FF, d[9:0]);
      chk("sp_pin", 1, o_io_out[0]);
      // Reset and preset terms both high at the clock edge
      setin(2, 1'b1);
      tck();
      rd(SOP_ADDR_STAT);
      chk("ar_sp", 0, d[9:0]);
      setin(2, 1'b0);
      setin(3, 1'b0);
      // Modes: term polarity, output polarity, input level
      for (int m = 0; m < 8; m++) begin
         pt(2, m[0] ? 44'h800000 : 44'h2);
         wr(SOP_ADDR_CFG, 32'h03FF03FE | m[1]);
         setin(1, m[2]);
         chk("comb", m[2] ^ m[0] ^ !m[1], o_io_out[0]);
      end
      pt(2, 44'h800002);
      st();
      chk("both", 0, o_io_out[0]);
      // Widest output: sixteen data terms after its enable term
      for (int t = 50; t < 66; t++) pt(t, pt_low);
      st();
      chk("pt16_lo", 0, o_io_out[4]);
      pt(65, '0);
      st();
      chk("pt16_hi", 1, o_io_out[4]);
      pt(1, 44'h10);
      setin(4, 1'b0);
      chk("oe_off", 0, o_io_oe[0]);
      setin(4, 1'b1);
      chk("oe_on", 1, o_io_oe[0]);
      pt(2, 44'h2000);
      for (int v = 0; v < 2; v++) begin
         @(posedge i_clk);
         drv    <= v ? 10'h3FF : 10'h000;
         drv_en <= 10'h3FF;
         st();
         chk("fb_pin", v, o_io_out[0]);
      end
      chk("in_only", 0, o_io_oe[1]);
      pt(0, pt_low);
      wr(SOP_ADDR_CFG, 32'h000003FF);
      @(posedge i_clk);
      i_preload <= 1'b1;
      drv       <= 10'h2A5;
      st();
      chk("pl_oe", 0, o_io_oe);
      tck();
      @(posedge i_clk);
      i_preload <= 1'b0;
      rd(SOP_ADDR_STAT);
      chk("pl_q", 10'h2A5, d[9:0]);
      // Second reset with flip-flops holding a non-zero state
      @(posedge i_clk);
      i_reset_n <= 1'b0;
      repeat (4) @(posedge i_clk);
      i_reset_n <= 1'b1;
      st();
      rd(SOP_ADDR_STAT);
      chk("rst_q", 32'h03FF0000, d);
      print_verdict();
   end
endmodule : sop_macrocell_array_bench

bind sop_macrocell_array sop_macrocell_array_asserts u_chk (.i_clk, .i_reset_n, .o_io_out,
   .o_io_oe, .i_preload, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata);
